/* File: rtl/dvsm_pkg.sv */
// Overview of operation
// R1 - A two-bit link field keeps left and right volumes separate (00) or makes right follow left (01).
// R2 - Left samples are scaled by an 8-bit code: 0 is +24 dB, 0x30 is 0 dB, each step is 0.5 dB less.
// R3 - Codes reach -103 dB at 0xfe, and code 0xff silences the channel fully.
// R4 - Right samples are scaled by their own code with the same coding and a 0 dB reset.
// R5 - Ramp-down updates happen every 1, 2 or 4 sample periods for rate codes 00, 01, 10; reset 00.
// R6 - Ramp-down rate code 11 mutes at once on a mute request.
// R7 - Each ramp-down update lowers the volume by 4, 2, 1 or 0.5 dB for step codes 00..11; reset 11.
// R8 - Ramp-up updates happen every 1, 2 or 4 sample periods for rate codes 00, 01, 10; reset 00.
// R9 - Ramp-up rate code 11 restores the programmed volume at once on unmute.
// R10 - Each ramp-up update raises the volume by 4, 2, 1 or 0.5 dB for step codes 00..11; reset 11.
// R11 - Ramp-down settings apply to mutes raised by the active-low pin or by the register bit.
// R12 - Ramp-up settings apply to unmutes raised by the active-low pin or by the register bit.
// R13 - A ramp stops exactly at its target; a last partial step never overshoots.
// Purpose: Constants, register map and helpers for the volume and soft-mute stage.
// Assumes: Registers sit on 32-bit words, byte address is four times the index.
// Notes:   Gain table covers one 6 dB octave in 0.5 dB steps.
package dvsm_pkg;

  localparam int SAMPLE_W = 24;
  localparam int CODE_W   = 8;

  // Register indices
  localparam logic [7:0] IDX_MUTE  = 8'h03;
  localparam logic [7:0] IDX_LINK  = 8'h3c;
  localparam logic [7:0] IDX_LEFT  = 8'h3d;
  localparam logic [7:0] IDX_RIGHT = 8'h3e;
  localparam logic [7:0] IDX_RAMP  = 8'h3f;
  localparam logic [7:0] IDX_STAT  = 8'h70;

  // Reset values
  localparam logic [1:0] LINK_RST = 2'h0;
  localparam logic [7:0] VOL_RST  = 8'h30;
  localparam logic [7:0] RAMP_RST = 8'h33;

  // Field positions
  localparam int LINK_W        = 2;
  localparam int FALL_RATE_LSB = 6;
  localparam int FALL_STEP_LSB = 4;
  localparam int RISE_RATE_LSB = 2;
  localparam int RISE_STEP_LSB = 0;
  localparam int MUTE_BIT      = 0;
  localparam int STAT_L_LSB    = 0;
  localparam int STAT_R_LSB    = 8;
  localparam int STAT_BUSY_BIT = 16;
  localparam int STAT_REQ_BIT  = 17;

  // Encodings
  localparam logic [1:0] LINK_FOLLOW = 2'h1;
  localparam logic [1:0] RATE_EVERY1 = 2'h0;
  localparam logic [1:0] RATE_EVERY2 = 2'h1;
  localparam logic [1:0] RATE_EVERY4 = 2'h2;
  localparam logic [1:0] RATE_INSTANT = 2'h3;
  localparam logic [7:0] CODE_MUTE   = 8'hff;
  localparam logic [7:0] STEP_4DB    = 8'h08;
  localparam logic [7:0] STEP_2DB    = 8'h04;
  localparam logic [7:0] STEP_1DB    = 8'h02;
  localparam logic [7:0] STEP_HALFDB = 8'h01;

  // Gain arithmetic: mantissa Q16, code 0 is 16x
  localparam logic [7:0] CODES_PER_OCT = 8'h0c;
  localparam int         MANT_FRAC_W   = 16;
  localparam int         HEADROOM_OCT  = 4;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  localparam logic [31:0] HADDR_HI_MASK    = 32'hfffffc00;

  function automatic logic [16:0] gain_mant(input logic [3:0] k);
    case (k)
      4'h0:    gain_mant = 17'h10000;
      4'h1:    gain_mant = 17'h0f1a2;
      4'h2:    gain_mant = 17'h0e412;
      4'h3:    gain_mant = 17'h0d745;
      4'h4:    gain_mant = 17'h0cb30;
      4'h5:    gain_mant = 17'h0bfc9;
      4'h6:    gain_mant = 17'h0b505;
      4'h7:    gain_mant = 17'h0aadc;
      4'h8:    gain_mant = 17'h0a145;
      4'h9:    gain_mant = 17'h09838;
      4'ha:    gain_mant = 17'h08fad;
      4'hb:    gain_mant = 17'h0879c;
      default: gain_mant = 17'h10000;
    endcase
  endfunction

endpackage

/* File: rtl/dvsm_gain.sv */
// Purpose: Scales a stereo sample pair by two volume codes, one register stage.
// Assumes: Codes already resolved for linking and ramping.
// Notes:   Results saturate to the sample width.
`timescale 1ns/100ps
module dvsm_gain #(
  parameter int SAMPLE_W = dvsm_pkg::SAMPLE_W
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       valid_i,
  input  wire logic signed [SAMPLE_W-1:0] left_i,
  input  wire logic signed [SAMPLE_W-1:0] right_i,
  input  wire logic [dvsm_pkg::CODE_W-1:0] code_l_i,
  input  wire logic [dvsm_pkg::CODE_W-1:0] code_r_i,
  output logic                            valid_o,
  output logic signed [SAMPLE_W-1:0]      left_o,
  output logic signed [SAMPLE_W-1:0]      right_o
);
  import dvsm_pkg::*;

  localparam int PW    = SAMPLE_W + 18;
  localparam int MAX_S = 2**(SAMPLE_W-1) - 1;
  localparam int MIN_S = -(2**(SAMPLE_W-1));

  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } dvsm_gain_st_t;

  dvsm_gain_st_t s_q;
  dvsm_gain_st_t s_d;

  function automatic logic signed [SAMPLE_W-1:0] scale(
    input logic signed [SAMPLE_W-1:0] smp,
    input logic [CODE_W-1:0]          code
  );
    logic [7:0]           oct;
    logic [7:0]           frac;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] shd;
    logic [5:0]           amt;
    oct  = code / CODES_PER_OCT;
    frac = code % CODES_PER_OCT;
    prod = PW'(smp) * PW'($signed({1'b0, gain_mant(frac[3:0])}));
    amt  = 6'(MANT_FRAC_W - HEADROOM_OCT) + oct[5:0];
    shd  = prod >>> amt;
    // R3 full mute code
    if (code == CODE_MUTE) begin
      scale = '0;
    end else if (shd > PW'(MAX_S)) begin
      scale = SAMPLE_W'(MAX_S);
    end else if (shd < PW'(MIN_S)) begin
      scale = SAMPLE_W'(MIN_S);
    end else begin
      scale = shd[SAMPLE_W-1:0];
    end
  endfunction

  always_comb begin
    s_d       = s_q;
    s_d.valid = valid_i;
    if (valid_i) begin
      // R2 left code scaling
      s_d.left  = scale(left_i, code_l_i);
      // R4 right code scaling
      s_d.right = scale(right_i, code_r_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign valid_o = s_q.valid;
  assign left_o  = s_q.left;
  assign right_o = s_q.right;

endmodule

/* File: rtl/dvsm_top.sv */
// Purpose: Stereo digital volume with soft mute ramps and an AHB-Lite register slave.
// Assumes: One sample pair per SAMPLE_VALID_I pulse, on the same clock.
// Notes:   Zero wait state bus; reads see a write made in the cycle before.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
module dvsm_top #(
  parameter int SAMPLE_W = dvsm_pkg::SAMPLE_W
) (
  input  wire logic                       REF_CLK_I,
  input  wire logic                       SRST_I,
  input  wire logic                       HSEL_I,
  input  wire logic [31:0]                HADDR_I,
  input  wire logic [1:0]                 HTRANS_I,
  input  wire logic                       HWRITE_I,
  input  wire logic [2:0]                 HSIZE_I,
  input  wire logic [31:0]                HWDATA_I,
  input  wire logic                       HREADY_I,
  output logic [31:0]                     HRDATA_O,
  output logic                            HREADYOUT_O,
  output logic                            HRESP_O,
  input  wire logic                       SOFT_MUTE_N_PIN_I,
  input  wire logic                       SAMPLE_VALID_I,
  input  wire logic signed [SAMPLE_W-1:0] SAMPLE_L_I,
  input  wire logic signed [SAMPLE_W-1:0] SAMPLE_R_I,
  output logic                            SAMPLE_VALID_O,
  output logic signed [SAMPLE_W-1:0]      SAMPLE_L_O,
  output logic signed [SAMPLE_W-1:0]      SAMPLE_R_O,
  output logic                            RAMP_BUSY_O
);
  import dvsm_pkg::*;

  typedef struct packed {
    logic [LINK_W-1:0] channel_link_select;
    logic [CODE_W-1:0] left_gain_code;
    logic [CODE_W-1:0] right_gain_code;
    logic [CODE_W-1:0] ramp_cfg;
    logic              soft_mute_reg_bit;
    logic [CODE_W-1:0] cur_l;
    logic [CODE_W-1:0] cur_r;
    logic [1:0]        fs_phase;
    logic [2:0]        pin_sync;
    logic              pin_mute;
    logic              busy;
    logic              dp_write;
    logic              dp_hit;
    logic [7:0]        dp_idx;
    logic [31:0]       rdata;
    logic              readyout;
  } dvsm_state_t;

  dvsm_state_t s_q;
  dvsm_state_t s_d;

  logic                mute_req;
  logic [CODE_W-1:0]   tgt_l;
  logic [CODE_W-1:0]   tgt_r;
  logic                ap_take;
  logic [1:0]          fall_rate;
  logic [1:0]          fall_step;
  logic [1:0]          rise_rate;
  logic [1:0]          rise_step;

  function automatic logic update_due(input logic [1:0] rate, input logic [1:0] phase);
    case (rate)
      RATE_EVERY1: update_due = 1'b1;
      RATE_EVERY2: update_due = (phase[0] == 1'b0);
      RATE_EVERY4: update_due = (phase == 2'h0);
      default:     update_due = 1'b1;
    endcase
  endfunction

  function automatic logic [CODE_W-1:0] step_size(input logic [1:0] sel);
    case (sel)
      2'h0:    step_size = STEP_4DB;
      2'h1:    step_size = STEP_2DB;
      2'h2:    step_size = STEP_1DB;
      default: step_size = STEP_HALFDB;
    endcase
  endfunction

  // Word index of a bus address
  function automatic logic [7:0] addr_index(input logic [31:0] addr);
    addr_index = addr[9:2];
  endfunction

  // Address lands on a register word
  function automatic logic addr_hit(input logic [31:0] addr);
    addr_hit = ((addr & HADDR_HI_MASK) == '0) && (addr[1:0] == 2'h0);
  endfunction

  // Channel target, mute code while a mute is requested
  function automatic logic [CODE_W-1:0] mute_target(
    input logic              mute,
    input logic [CODE_W-1:0] prog
  );
    mute_target = mute ? CODE_MUTE : prog;
  endfunction

  // One ramp update of a channel toward its target
  function automatic logic [CODE_W-1:0] ramp_next(
    input logic [CODE_W-1:0] cur,
    input logic [CODE_W-1:0] tgt,
    input logic [1:0]        frate,
    input logic [1:0]        fstep,
    input logic [1:0]        rrate,
    input logic [1:0]        rstep,
    input logic [1:0]        phase,
    input logic              tick
  );
    logic [CODE_W-1:0] st;
    ramp_next = cur;
    if (cur < tgt) begin
      st = step_size(fstep);
      // R6 instant mute
      if (frate == RATE_INSTANT) begin
        ramp_next = tgt;
      // R5 fall update rate
      end else if (tick && update_due(frate, phase)) begin
        // R7 fall step, R13 clamp at target
        if ((tgt - cur) <= st) begin
          ramp_next = tgt;
        end else begin
          ramp_next = cur + st;
        end
      end
    end else if (cur > tgt) begin
      st = step_size(rstep);
      // R9 instant unmute
      if (rrate == RATE_INSTANT) begin
        ramp_next = tgt;
      // R8 rise update rate
      end else if (tick && update_due(rrate, phase)) begin
        // R10 rise step, R13 clamp at target
        if ((cur - tgt) <= st) begin
          ramp_next = tgt;
        end else begin
          ramp_next = cur - st;
        end
      end
    end
  endfunction

  function automatic logic [31:0] reg_read(input dvsm_state_t s, input logic [7:0] idx);
    reg_read = '0;
    case (idx)
      IDX_MUTE:  reg_read[MUTE_BIT] = s.soft_mute_reg_bit;
      IDX_LINK:  reg_read[LINK_W-1:0] = s.channel_link_select;
      IDX_LEFT:  reg_read[CODE_W-1:0] = s.left_gain_code;
      IDX_RIGHT: reg_read[CODE_W-1:0] = s.right_gain_code;
      IDX_RAMP:  reg_read[CODE_W-1:0] = s.ramp_cfg;
      IDX_STAT: begin
        reg_read[STAT_L_LSB +: CODE_W] = s.cur_l;
        reg_read[STAT_R_LSB +: CODE_W] = s.cur_r;
        reg_read[STAT_BUSY_BIT]        = s.busy;
        reg_read[STAT_REQ_BIT]         = s.pin_mute | s.soft_mute_reg_bit;
      end
      default:   reg_read = '0;
    endcase
  endfunction

  always_comb begin
    s_d = s_q;

    // Pin synchroniser: change taken when stages two and three agree
    s_d.pin_sync = {s_q.pin_sync[1:0], SOFT_MUTE_N_PIN_I};
    if (s_q.pin_sync[1] == s_q.pin_sync[2]) begin
      s_d.pin_mute = ~s_q.pin_sync[2];
    end

    // Bus data phase: register write
    if (s_q.dp_write && s_q.dp_hit) begin
      case (s_q.dp_idx)
        IDX_MUTE:  s_d.soft_mute_reg_bit = HWDATA_I[MUTE_BIT];
        IDX_LINK:  s_d.channel_link_select = HWDATA_I[LINK_W-1:0];
        IDX_LEFT:  s_d.left_gain_code = HWDATA_I[CODE_W-1:0];
        IDX_RIGHT: s_d.right_gain_code = HWDATA_I[CODE_W-1:0];
        IDX_RAMP:  s_d.ramp_cfg = HWDATA_I[CODE_W-1:0];
        default:   s_d.dp_hit = 1'b0;
      endcase
    end

    // Bus address phase
    ap_take = HSEL_I && HTRANS_I[1] && HREADY_I;
    if (ap_take) begin
      s_d.dp_write = HWRITE_I;
      s_d.dp_hit   = addr_hit(HADDR_I);
      s_d.dp_idx   = addr_index(HADDR_I);
      if (!HWRITE_I) begin
        s_d.rdata = s_d.dp_hit ? reg_read(s_d, addr_index(HADDR_I)) : '0;
      end
    end else begin
      s_d.dp_write = 1'b0;
      s_d.dp_hit   = 1'b0;
    end
    s_d.readyout = 1'b1;

    // R11 R12 either source raises a mute
    mute_req = s_q.pin_mute | s_q.soft_mute_reg_bit;

    tgt_l = mute_target(mute_req, s_q.left_gain_code);
    // R1 right follows left when linked
    if (s_q.channel_link_select == LINK_FOLLOW) begin
      tgt_r = tgt_l;
    end else begin
      tgt_r = mute_target(mute_req, s_q.right_gain_code);
    end

    fall_rate = s_q.ramp_cfg[FALL_RATE_LSB +: 2];
    fall_step = s_q.ramp_cfg[FALL_STEP_LSB +: 2];
    rise_rate = s_q.ramp_cfg[RISE_RATE_LSB +: 2];
    rise_step = s_q.ramp_cfg[RISE_STEP_LSB +: 2];

    s_d.cur_l = ramp_next(s_q.cur_l, tgt_l, fall_rate, fall_step, rise_rate,
                          rise_step, s_q.fs_phase, SAMPLE_VALID_I);
    s_d.cur_r = ramp_next(s_q.cur_r, tgt_r, fall_rate, fall_step, rise_rate,
                          rise_step, s_q.fs_phase, SAMPLE_VALID_I);
    if (SAMPLE_VALID_I) begin
      s_d.fs_phase = s_q.fs_phase + 2'h1;
    end
    s_d.busy = (s_d.cur_l != tgt_l) || (s_d.cur_r != tgt_r);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      s_q                     <= '0;
      s_q.channel_link_select <= LINK_RST;
      // R2 R4 reset to 0 dB
      s_q.left_gain_code      <= VOL_RST;
      s_q.right_gain_code     <= VOL_RST;
      s_q.cur_l               <= VOL_RST;
      s_q.cur_r               <= VOL_RST;
      s_q.ramp_cfg            <= RAMP_RST;
      s_q.pin_sync            <= '1;
      s_q.readyout            <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  dvsm_gain #(
    .SAMPLE_W (SAMPLE_W)
  ) u_gain (
    .clk_i    (REF_CLK_I),
    .srst_i   (SRST_I),
    .valid_i  (SAMPLE_VALID_I),
    .left_i   (SAMPLE_L_I),
    .right_i  (SAMPLE_R_I),
    .code_l_i (s_q.cur_l),
    .code_r_i (s_q.cur_r),
    .valid_o  (SAMPLE_VALID_O),
    .left_o   (SAMPLE_L_O),
    .right_o  (SAMPLE_R_O)
  );

  assign HRDATA_O    = s_q.rdata;
  assign HREADYOUT_O = s_q.readyout;
  assign HRESP_O     = 1'b0;
  assign RAMP_BUSY_O = s_q.busy;

endmodule

/* File: dv/dvsm_src.sv */
// Purpose: Sample source standing in for the serial audio input.
// Assumes: One pulse every gap_i+1 cycles, gap set by the bench.
// Notes:   Data lines toggle between pulses so stale values never look valid.
`timescale 1ns/100ps
module dvsm_src (
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic [2:0]         gap_i,
  input  wire logic signed [23:0] lvl_l_i,
  input  wire logic signed [23:0] lvl_r_i,
  output logic                    vld_o,
  output logic signed [23:0]      l_o,
  output logic signed [23:0]      r_o
);
  logic [2:0] cnt_q;
  logic       hit;
  assign hit = cnt_q >= gap_i;
  always_ff @(posedge clk_i) begin
    cnt_q <= (srst_i || hit) ? 3'h0 : cnt_q + 3'h1;
    vld_o <= !srst_i && hit;
    l_o   <= hit ? lvl_l_i : ~l_o;
    r_o   <= hit ? lvl_r_i : ~r_o;
  end
endmodule

/* File: dv/dvsm_chk_sva.sv */
// Purpose: Port-level checks for the volume and soft-mute stage.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every top instance.
`timescale 1ns/100ps
module dvsm_chk #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                       REF_CLK_I,
  input wire logic                       SRST_I,
  input wire logic                       HSEL_I,
  input wire logic [1:0]                 HTRANS_I,
  input wire logic                       HWRITE_I,
  input wire logic                       HREADY_I,
  input wire logic [31:0]                HRDATA_O,
  input wire logic                       HREADYOUT_O,
  input wire logic                       HRESP_O,
  input wire logic                       SOFT_MUTE_N_PIN_I,
  input wire logic                       SAMPLE_VALID_I,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_L_I,
  input wire logic                       SAMPLE_VALID_O,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_L_O,
  input wire logic signed [SAMPLE_W-1:0] SAMPLE_R_O,
  input wire logic                       RAMP_BUSY_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SRST_I);
  a_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("bus response not okay");
  a_no_wait: assert property (HREADYOUT_O)
    else $error("slave inserted wait state");
  a_rdata_hold: assert property (!(HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I)
    |=> $stable(HRDATA_O)) else $error("read data changed without read");
  a_valid_next:
    assert property (SAMPLE_VALID_I |=> SAMPLE_VALID_O) else $error("output pulse missing");
  a_valid_once:
    assert property (!SAMPLE_VALID_I |=> !SAMPLE_VALID_O) else $error("extra output pulse");
  a_out_hold:
    assert property (!SAMPLE_VALID_O |-> $stable(SAMPLE_L_O) && $stable(SAMPLE_R_O))
    else $error("output sample changed without pulse");
  a_zero_gain:
    assert property (SAMPLE_VALID_I && SAMPLE_L_I == '0 |=> SAMPLE_L_O == '0)
    else $error("zero input gave nonzero output");
  a_mute_silent:
    assert property (!SOFT_MUTE_N_PIN_I [*8] ##0 !RAMP_BUSY_O ##0 SAMPLE_VALID_I
    |=> SAMPLE_L_O == '0 && SAMPLE_R_O == '0) else $error("muted output not silent");
endmodule
bind dvsm_top dvsm_chk #(
  .SAMPLE_W (SAMPLE_W)
) u_chk (
  .REF_CLK_I         (REF_CLK_I),
  .SRST_I            (SRST_I),
  .HSEL_I            (HSEL_I),
  .HTRANS_I          (HTRANS_I),
  .HWRITE_I          (HWRITE_I),
  .HREADY_I          (HREADY_I),
  .HRDATA_O          (HRDATA_O),
  .HREADYOUT_O       (HREADYOUT_O),
  .HRESP_O           (HRESP_O),
  .SOFT_MUTE_N_PIN_I (SOFT_MUTE_N_PIN_I),
  .SAMPLE_VALID_I    (SAMPLE_VALID_I),
  .SAMPLE_L_I        (SAMPLE_L_I),
  .SAMPLE_VALID_O    (SAMPLE_VALID_O),
  .SAMPLE_L_O        (SAMPLE_L_O),
  .SAMPLE_R_O        (SAMPLE_R_O),
  .RAMP_BUSY_O       (RAMP_BUSY_O)
);

/* File: dv/test_digital_volume_soft_mute.sv */
// Purpose: Self-checking bench for the volume and soft-mute stage.
// Assumes: Zero wait state register slave, sample source every few cycles.
// Notes:   Ramp length judged by output samples seen while busy.
`timescale 1ns/100ps
module test_digital_volume_soft_mute;
  logic               clk = 1'b0, srst = 1'b1, hwrite = 1'b0, pin_n = 1'b1;
  logic               hready, hresp, vld_i, vld_o, busy;
  logic [1:0]         htrans = 2'h0;
  logic [2:0]         gap = 3'h3;
  logic [31:0]        haddr = '0, hwdata = '0, hrdata;
  logic signed [23:0] lvl_l = 24'h001000, lvl_r = 24'hfff000;
  logic signed [23:0] smp_l, smp_r, out_l, out_r;
  int                 num_errors = 0, n_checks = 0;
  always #2 clk = ~clk;
  dvsm_src u_src (.clk_i(clk), .srst_i(srst), .gap_i(gap), .lvl_l_i(lvl_l),
    .lvl_r_i(lvl_r), .vld_o(vld_i), .l_o(smp_l), .r_o(smp_r));
  dvsm_top uut (.REF_CLK_I(clk), .SRST_I(srst), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .SOFT_MUTE_N_PIN_I(pin_n), .SAMPLE_VALID_I(vld_i), .SAMPLE_L_I(smp_l),
    .SAMPLE_R_I(smp_r), .SAMPLE_VALID_O(vld_o), .SAMPLE_L_O(out_l),
    .SAMPLE_R_O(out_r), .RAMP_BUSY_O(busy));
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    num_errors++;
    $display("Error %0t: wait timed out", $time);
    complete_run();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("Error %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic rdy;
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hready === 1'b1) break;
    end
    if (hready !== 1'b1) tmo();
  endtask
  task automatic bus(input logic [31:0] a, d, input logic w, output logic [31:0] q);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(a, d, 1'b1, q);
  endtask
  task automatic rdc(input logic [31:0] a, e);
    logic [31:0] q;
    bus(a, '0, 1'b0, q);
    chk(q, e);
  endtask
  task automatic get_smp(output logic [23:0] l, r);
    int i;
    int n;
    n = 0;
    for (i = 0; i < 100 && n < 2; i++) begin
      @(posedge clk);
      if (vld_o === 1'b1) n++;
    end
    if (n < 2) tmo();
    l = out_l;
    r = out_r;
  endtask
  task automatic gcase(input logic [7:0] cl, cr, input logic [1:0] lk,
                       input logic [23:0] el, er);
    logic [23:0] l;
    logic [23:0] r;
    wr(32'hf0, {30'h0, lk});
    wr(32'hf4, {24'h0, cl});
    wr(32'hf8, {24'h0, cr});
    get_smp(l, r);
    chk({8'h0, l}, {8'h0, el});
    chk({8'h0, r}, {8'h0, er});
  endtask
  task automatic t_regs;
    rdc(32'hf0, 32'h0);
    rdc(32'hf4, 32'h30);
    rdc(32'hf8, 32'h30);
    rdc(32'hfc, 32'h33);
    rdc(32'h0c, 32'h0);
    wr(32'h100, 32'hff);
    wr(32'h1c0, 32'h0);
    rdc(32'h100, 32'h0);
    rdc(32'h1c0, 32'h3030);
    wr(32'hf0, 32'hff);
    rdc(32'hf0, 32'h3);
  endtask
  task automatic t_gain;
    logic [23:0] l;
    logic [23:0] r;
    wr(32'hfc, 32'hff);
    gcase(8'h30, 8'h30, 2'h0, 24'h001000, 24'hfff000);
    gcase(8'h24, 8'h3c, 2'h0, 24'h002000, 24'hfff800);
    gcase(8'h00, 8'h30, 2'h0, 24'h010000, 24'hfff000);
    gcase(8'h24, 8'h3c, 2'h1, 24'h002000, 24'hffe000);
    gcase(8'h24, 8'h3c, 2'h2, 24'h002000, 24'hfff800);
    gcase(8'hff, 8'h30, 2'h0, 24'h000000, 24'hfff000);
    wr(32'hf4, 32'hfe);
    lvl_l <= 24'h7fffff;
    get_smp(l, r);
    chk({31'h0, l != 24'h0}, 32'h1);
    wr(32'hf0, 32'h0);
    wr(32'hf4, 32'h30);
    lvl_l <= 24'h000000;
    get_smp(l, r);
    chk({8'h0, l}, 32'h0);
    chk({8'h0, r}, 32'h00fff000);
    lvl_l <= 24'h001000;
  endtask
  task automatic ramp(input logic [1:0] r, s, input logic dn);
    int c;
    int i;
    int n;
    logic [31:0] q;
    n = (207 + (8 >> s) - 1) / (8 >> s);
    @(posedge clk);
    if (s[0]) pin_n <= !dn;
    else wr(32'h0c, {31'h0, dn});
    if (r == 2'h3) begin
      repeat (12) @(posedge clk);
    end else begin
      c = 0;
      for (i = 0; i < 40 && busy !== 1'b1; i++) @(posedge clk);
      for (i = 0; i < 40000 && busy !== 1'b0; i++) begin
        @(posedge clk);
        if (vld_o === 1'b1) c++;
      end
      if (busy !== 1'b0) tmo();
      chk_rng(c, (n - 1) << r, (n << r) + 4);
    end
    bus(32'h1c0, '0, 1'b0, q);
    chk(q & 32'hffff, dn ? 32'hffff : 32'h3030);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_gain();
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge clk);
        gap <= (r == 2) ? 3'h7 : 3'h3;
        wr(32'hfc, {24'h0, 2'(r), 2'(s), 2'(r), 2'(s)});
        ramp(2'(r), 2'(s), 1'b1);
        ramp(2'(r), 2'(s), 1'b0);
      end
    end
    complete_run();
  end
endmodule
